// ==== core/serializer_config_regs.sv ====
// apb register bank holding video filter, self-test and sensor configuration
//
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
// Behaviour
// - any-long-type pass forwards every long data type packet to the video port.
// - type match enable forwards packets whose type equals the match value.
// - while type match is enabled, writes to the match value are ignored.
// - yuv pass with hundred-mhz mode forwards types 0x19, 0x1D, 0x1F.
// - frame valid invert flips frame valid polarity on the video port.
// - line valid invert flips line valid polarity on the video port.
// - a matched type passes regardless of the 75 or 100 mhz mode.
// - match only happens if match value bit 5 or bit 4 is set.
// - a seven-bit count holds how many parity errors to inject.
// - entering self-test mode starts injection of the programmed count automatically.
// - in normal mode injection starts on writing one to the self-clearing trigger.
// - four-bit force field enables forced errors when nonzero.
// - local self-test enable puts the device into self-test mode.
// - clock select 00 system, 01 50 mhz, 1x 25 mhz.
// - a backward compatible remote self-test enable bit is held.
// - voltage gain equals 128 divided by the seven-bit gain code.
// - sensor enable 00 disables, 11 enables temperature and voltage sensors.
// - sensing select 00 none, 01 gpio0, 10 gpio1, 11 both.
// - gain enable bit applies the gain code to the sensor.
module serializer_config_regs
    import ser_cfg_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // packet type filter inputs
    input wire logic pkt_valid,
    input wire logic [ser_cfg_pkg::TYPE_CODE_W-1:0] packet_type_code,
    input wire logic hundred_mhz_mode,
    input wire logic seventy_five_mhz_mode,
    input wire logic frame_valid_in,
    input wire logic line_valid_in,
    // video port outputs
    output logic pkt_forward,
    output logic frame_valid_out,
    output logic line_valid_out,
    // self-test status input and outputs
    input wire logic parity_error_done,
    output logic self_test_mode,
    output logic remote_self_test_enable,
    output logic [1:0] self_test_clock_select,
    output logic force_errors_enable,
    output logic inject_start,
    output logic [ser_cfg_pkg::FORCED_COUNT_W-1:0] forced_error_count,
    // sensor outputs
    output logic sensors_enable,
    output logic sense_gpio0,
    output logic sense_gpio1,
    output logic gain_apply,
    output logic [ser_cfg_pkg::GAIN_CODE_W-1:0] voltage_gain_code
);
    import ser_cfg_pkg::*;

    logic [7:0] video_filter_config;
    logic [7:0] video_type_match_value;
    logic [7:0] self_test_force_error;
    logic [7:0] self_test_control;
    logic [7:0] sensor_voltage_gain;
    logic [7:0] sensor_control_first;
    logic [7:0] sensor_control_second;
    logic self_test_prev;
    logic wr_en;
    logic [7:0] wr_byte;
    logic [9:0] idx;
    logic addr_ok;
    logic [7:0] rd_byte;
    logic match_hit;
    logic yuv_hit;
    logic long_hit;

    // zero wait states: access phase completes in the cycle it starts
    assign idx = paddr[11:2];
    // only byte lane 0 carries data; a write with lane 0 off leaves the register alone
    assign wr_en = psel && penable && pwrite && pstrb[0] && addr_ok && (paddr[1:0] == 2'h0);
    assign wr_byte = pwdata[7:0];

    // address decode and read mux
    always_comb begin
        addr_ok = 1'b1;
        rd_byte = 8'h00;
        unique case (idx)
            {2'h0, IDX_VIDEO_FILTER_CONFIG}: rd_byte = video_filter_config;
            {2'h0, IDX_VIDEO_TYPE_MATCH_VALUE}: rd_byte = video_type_match_value;
            {2'h0, IDX_SELF_TEST_FORCE_ERROR}: rd_byte = self_test_force_error;
            {2'h0, IDX_SELF_TEST_CONTROL}: rd_byte = self_test_control;
            {2'h0, IDX_SENSOR_VOLTAGE_GAIN}: rd_byte = sensor_voltage_gain;
            {2'h0, IDX_SENSOR_CONTROL_FIRST}: rd_byte = sensor_control_first;
            {2'h0, IDX_SENSOR_CONTROL_SECOND}: rd_byte = sensor_control_second;
            default: addr_ok = 1'b0;
        endcase
    end

    // apb answer registered at setup so it stands during the access phase
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            prdata <= (psel && !penable && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            pslverr <= psel && !penable && !(addr_ok && (paddr[1:0] == 2'h0));
        end
    end

    // video filter config; reserved bits kept as written
    // reserved storage
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            video_filter_config <= RST_VIDEO_FILTER_CONFIG;
        end else if (wr_en && pready && idx == {2'h0, IDX_VIDEO_FILTER_CONFIG}) begin
            video_filter_config <= wr_byte;
        end
    end

    // match value; locked while matching so the filter never sees a half-changed key
    // write block
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            video_type_match_value <= RST_VIDEO_TYPE_MATCH_VALUE;
        end else if (wr_en && pready && idx == {2'h0, IDX_VIDEO_TYPE_MATCH_VALUE}
                     && !video_filter_config[BIT_TYPE_MATCH_ENABLE]) begin
            video_type_match_value <= wr_byte;
        end
    end

    // force error register; trigger bit self-clears after one cycle
    // count field
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            self_test_force_error <= RST_SELF_TEST_FORCE_ERROR;
        end else if (wr_en && pready && idx == {2'h0, IDX_SELF_TEST_FORCE_ERROR}) begin
            self_test_force_error <= wr_byte;
        end else begin
            self_test_force_error[BIT_FORCE_PARITY_TRIGGER] <= 1'b0;
        end
    end

    // test control
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            self_test_control <= RST_SELF_TEST_CONTROL;
        end else if (wr_en && pready && idx == {2'h0, IDX_SELF_TEST_CONTROL}) begin
            self_test_control <= wr_byte;
        end
    end

    // sensor registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sensor_voltage_gain <= RST_SENSOR_VOLTAGE_GAIN;
            sensor_control_first <= RST_SENSOR_CONTROL_FIRST;
            sensor_control_second <= RST_SENSOR_CONTROL_SECOND;
        end else if (wr_en && pready) begin
            if (idx == {2'h0, IDX_SENSOR_VOLTAGE_GAIN}) begin
                sensor_voltage_gain <= wr_byte;
            end
            if (idx == {2'h0, IDX_SENSOR_CONTROL_FIRST}) begin
                sensor_control_first <= wr_byte;
            end
            if (idx == {2'h0, IDX_SENSOR_CONTROL_SECOND}) begin
                sensor_control_second <= wr_byte;
            end
        end
    end

    // filter decisions
    // long type check
    assign long_hit = packet_type_code[BIT_LONG_HI] || packet_type_code[BIT_LONG_LO];
    assign match_hit = video_filter_config[BIT_TYPE_MATCH_ENABLE]
        && (packet_type_code == video_type_match_value[TYPE_CODE_W-1:0])
        && (video_type_match_value[BIT_LONG_HI] || video_type_match_value[BIT_LONG_LO]);
    assign yuv_hit = video_filter_config[BIT_YUV_TEN_BIT_PASS] && hundred_mhz_mode
        && (packet_type_code == YUV_TYPE_A || packet_type_code == YUV_TYPE_B
            || packet_type_code == YUV_TYPE_C);

    // registered video port; seventy_five_mhz_mode has no effect on the paths kept here
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pkt_forward <= 1'b0;
            frame_valid_out <= 1'b0;
            line_valid_out <= 1'b0;
        end else begin
            pkt_forward <= pkt_valid && ((video_filter_config[BIT_ANY_LONG_TYPE_PASS] && long_hit)
                || match_hit || yuv_hit);
            frame_valid_out <= frame_valid_in ^ video_filter_config[BIT_FRAME_VALID_INVERT];
            line_valid_out <= line_valid_in ^ video_filter_config[BIT_LINE_VALID_INVERT];
        end
    end

    // self-test outputs; injection start is a one-cycle pulse
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            self_test_prev <= 1'b0;
            self_test_mode <= 1'b0;
            remote_self_test_enable <= 1'b0;
            self_test_clock_select <= CLK_SRC_SYSTEM;
            force_errors_enable <= 1'b0;
            inject_start <= 1'b0;
            forced_error_count <= '0;
        end else begin
            self_test_prev <= self_test_control[BIT_LOCAL_SELF_TEST_ENABLE];
            self_test_mode <= self_test_control[BIT_LOCAL_SELF_TEST_ENABLE];
            remote_self_test_enable <= self_test_control[BIT_REMOTE_SELF_TEST_ENABLE];
            if (self_test_control[CLK_SEL_LSB+1]) begin
                self_test_clock_select <= CLK_SRC_25M;
            end else if (self_test_control[CLK_SEL_LSB]) begin
                self_test_clock_select <= CLK_SRC_50M;
            end else begin
                self_test_clock_select <= CLK_SRC_SYSTEM;
            end
            force_errors_enable <= self_test_control[FORCE_FIELD_LSB +: 4] != 4'h0;
            inject_start <= (self_test_control[BIT_LOCAL_SELF_TEST_ENABLE] && !self_test_prev)
                || (!self_test_control[BIT_LOCAL_SELF_TEST_ENABLE]
                    && self_test_force_error[BIT_FORCE_PARITY_TRIGGER]);
            forced_error_count <= self_test_force_error[FORCED_COUNT_W-1:0];
        end
    end

    // sensor outputs; the divide is left to the analog side since only the code crosses
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sensors_enable <= 1'b0;
            sense_gpio0 <= 1'b0;
            sense_gpio1 <= 1'b0;
            gain_apply <= 1'b0;
            voltage_gain_code <= '0;
        end else begin
            sensors_enable <= sensor_control_first[SENSOR_EN_LSB +: 2] == SENSOR_EN_ON;
            sense_gpio0 <= sensor_control_first[SENSE_SEL_LSB];
            sense_gpio1 <= sensor_control_first[SENSE_SEL_LSB+1];
            gain_apply <= sensor_control_second[BIT_SENSE_GAIN_ENABLE];
            // gain code, gain = 128 / code
            voltage_gain_code <= sensor_voltage_gain[GAIN_CODE_W-1:0];
        end
    end

    // assertions
    property p_match_lock;
        @(posedge clk_sys) disable iff (!rst_n)
        video_filter_config[BIT_TYPE_MATCH_ENABLE] |=> $stable(video_type_match_value);
    endproperty
    a_match_lock: assert property (p_match_lock) else $error("match value changed while locked");

    property p_any_long;
        @(posedge clk_sys) disable iff (!rst_n)
        pkt_valid && video_filter_config[BIT_ANY_LONG_TYPE_PASS] && long_hit |=> pkt_forward;
    endproperty
    a_any_long: assert property (p_any_long) else $error("long packet not forwarded");

    property p_match_fwd;
        @(posedge clk_sys) disable iff (!rst_n)
        pkt_valid && match_hit |=> pkt_forward;
    endproperty
    a_match_fwd: assert property (p_match_fwd) else $error("matched packet not forwarded");

    property p_short_match;
        @(posedge clk_sys) disable iff (!rst_n)
        !video_type_match_value[BIT_LONG_HI] && !video_type_match_value[BIT_LONG_LO] |-> !match_hit;
    endproperty
    a_short_match: assert property (p_short_match) else $error("short type matched");

    property p_yuv;
        @(posedge clk_sys) disable iff (!rst_n)
        pkt_valid && video_filter_config[BIT_YUV_TEN_BIT_PASS] && hundred_mhz_mode
            && packet_type_code == YUV_TYPE_B |=> pkt_forward;
    endproperty
    a_yuv: assert property (p_yuv) else $error("yuv packet not forwarded");

    property p_fv_inv;
        @(posedge clk_sys) disable iff (!rst_n)
        1'b1 |=> frame_valid_out == ($past(frame_valid_in) ^ $past(video_filter_config[BIT_FRAME_VALID_INVERT]));
    endproperty
    a_fv_inv: assert property (p_fv_inv) else $error("frame valid polarity wrong");

    property p_lv_inv;
        @(posedge clk_sys) disable iff (!rst_n)
        1'b1 |=> line_valid_out == ($past(line_valid_in) ^ $past(video_filter_config[BIT_LINE_VALID_INVERT]));
    endproperty
    a_lv_inv: assert property (p_lv_inv) else $error("line valid polarity wrong");

    property p_trigger_clear;
        @(posedge clk_sys) disable iff (!rst_n)
        self_test_force_error[BIT_FORCE_PARITY_TRIGGER] && !(wr_en && pready)
            |=> !self_test_force_error[BIT_FORCE_PARITY_TRIGGER];
    endproperty
    a_trigger_clear: assert property (p_trigger_clear) else $error("trigger did not self-clear");

    property p_bist_entry;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(self_test_control[BIT_LOCAL_SELF_TEST_ENABLE]) |-> ##1 inject_start ##0 self_test_mode;
    endproperty
    a_bist_entry: assert property (p_bist_entry) else $error("no injection on self-test entry");

    property p_sens_en;
        @(posedge clk_sys) disable iff (!rst_n)
        sensor_control_first[SENSOR_EN_LSB +: 2] == 2'h0 |=> !sensors_enable;
    endproperty
    a_sens_en: assert property (p_sens_en) else $error("sensors enabled with code 00");

    c_match: cover property (@(posedge clk_sys) disable iff (!rst_n) pkt_valid && match_hit ##1 pkt_forward);
    c_inject: cover property (@(posedge clk_sys) disable iff (!rst_n) inject_start && !self_test_mode);
    c_bist: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(self_test_mode));
    c_locked_write: cover property (@(posedge clk_sys) disable iff (!rst_n)
        wr_en && pready && video_filter_config[BIT_TYPE_MATCH_ENABLE]
        && idx == {2'h0, IDX_VIDEO_TYPE_MATCH_VALUE});
endmodule

// ==== shared/ser_cfg_pkg.sv ====
// constants for the serializer configuration register bank
package ser_cfg_pkg;
    // printed offsets are not all multiples of four: these are indices, byte address = index * 4
    localparam logic [7:0] IDX_VIDEO_FILTER_CONFIG = 8'h10;
    localparam logic [7:0] IDX_VIDEO_TYPE_MATCH_VALUE = 8'h11;
    localparam logic [7:0] IDX_SELF_TEST_FORCE_ERROR = 8'h13;
    localparam logic [7:0] IDX_SELF_TEST_CONTROL = 8'h14;
    localparam logic [7:0] IDX_SENSOR_VOLTAGE_GAIN = 8'h15;
    localparam logic [7:0] IDX_SENSOR_CONTROL_FIRST = 8'h17;
    localparam logic [7:0] IDX_SENSOR_CONTROL_SECOND = 8'h18;
    // reset values
    localparam logic [7:0] RST_VIDEO_FILTER_CONFIG = 8'h00;
    localparam logic [7:0] RST_VIDEO_TYPE_MATCH_VALUE = 8'h00;
    localparam logic [7:0] RST_SELF_TEST_FORCE_ERROR = 8'h00;
    localparam logic [7:0] RST_SELF_TEST_CONTROL = 8'h00;
    localparam logic [7:0] RST_SENSOR_VOLTAGE_GAIN = 8'h20;
    localparam logic [7:0] RST_SENSOR_CONTROL_FIRST = 8'h3C;
    localparam logic [7:0] RST_SENSOR_CONTROL_SECOND = 8'h80;
    // video_filter_config fields
    localparam int BIT_ANY_LONG_TYPE_PASS = 4;
    localparam int BIT_TYPE_MATCH_ENABLE = 3;
    localparam int BIT_YUV_TEN_BIT_PASS = 2;
    localparam int BIT_FRAME_VALID_INVERT = 1;
    localparam int BIT_LINE_VALID_INVERT = 0;
    // type match value and long-type bits
    localparam int TYPE_CODE_W = 6;
    localparam int BIT_LONG_HI = 5;
    localparam int BIT_LONG_LO = 4;
    localparam logic [5:0] YUV_TYPE_A = 6'h19;
    localparam logic [5:0] YUV_TYPE_B = 6'h1D;
    localparam logic [5:0] YUV_TYPE_C = 6'h1F;
    // self_test_force_error fields
    localparam int BIT_FORCE_PARITY_TRIGGER = 7;
    localparam int FORCED_COUNT_W = 7;
    // self_test_control fields
    localparam int FORCE_FIELD_LSB = 4;
    localparam int BIT_LOCAL_SELF_TEST_ENABLE = 3;
    localparam int CLK_SEL_LSB = 1;
    localparam int BIT_REMOTE_SELF_TEST_ENABLE = 0;
    // test clock sources
    localparam logic [1:0] CLK_SRC_SYSTEM = 2'h0;
    localparam logic [1:0] CLK_SRC_50M = 2'h1;
    localparam logic [1:0] CLK_SRC_25M = 2'h2;
    // sensor fields
    localparam int GAIN_CODE_W = 7;
    localparam int SENSOR_EN_LSB = 2;
    localparam logic [1:0] SENSOR_EN_ON = 2'h3;
    localparam int SENSE_SEL_LSB = 0;
    localparam int BIT_SENSE_GAIN_ENABLE = 7;
endpackage

// ==== test/serializer_config_regs_bench.sv ====
// self-checking bench for the serializer configuration register bank
`timescale 1ns/10ps
module serializer_config_regs_bench;
    import ser_cfg_pkg::*;
    localparam logic [7:0] FLT = IDX_VIDEO_FILTER_CONFIG;
    localparam logic [7:0] MV = IDX_VIDEO_TYPE_MATCH_VALUE;
    localparam logic [7:0] FE = IDX_SELF_TEST_FORCE_ERROR;
    localparam logic [7:0] CTL = IDX_SELF_TEST_CONTROL;
    localparam logic [7:0] GN = IDX_SENSOR_VOLTAGE_GAIN;
    localparam logic [7:0] SC0 = IDX_SENSOR_CONTROL_FIRST;
    localparam logic [7:0] SC1 = IDX_SENSOR_CONTROL_SECOND;
    // design ports
    logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb, strb;
    logic pkt_valid, hundred_mhz_mode, seventy_five_mhz_mode, frame_valid_in, line_valid_in;
    logic [5:0] packet_type_code;
    logic pkt_forward, frame_valid_out, line_valid_out, self_test_mode, remote_self_test_enable;
    logic force_errors_enable, inject_start, sensors_enable, sense_gpio0, sense_gpio1, gain_apply;
    logic [1:0] self_test_clock_select;
    logic [6:0] forced_error_count, voltage_gain_code;
    // bench state: sh mirrors what software should read back
    int errors = 0, samples_checked = 0, inj_cnt = 0, n0, seed = 54798;
    logic [7:0] sh [0:255];
    logic [7:0] regs [7] = '{FLT, MV, FE, CTL, GN, SC0, SC1};
    logic [7:0] d;
    logic [9:0] expq [$];
    logic [9:0] e;

    serializer_config_regs serializer_config_regs_inst (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .pready, .prdata, .pslverr, .pkt_valid, .packet_type_code, .hundred_mhz_mode,
        .seventy_five_mhz_mode, .frame_valid_in, .line_valid_in, .pkt_forward, .frame_valid_out,
        .line_valid_out, .parity_error_done(1'b0), .self_test_mode, .remote_self_test_enable,
        .self_test_clock_select, .force_errors_enable, .inject_start, .forced_error_count, .sensors_enable,
        .sense_gpio0, .sense_gpio1, .gain_apply, .voltage_gain_code);

    // 125 mhz system clock
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic cmp_out(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bus(input logic [32:0] got, input logic [32:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // bus answers are matched against the oldest noted expectation; error reads carry no data check
    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1) begin
            e = (expq.size() > 0) ? expq.pop_front() : 10'h3FF;
            cmp_bus({pslverr, e[9] ? prdata : 32'h0}, {e[8], 24'h0, e[9] ? e[7:0] : 8'h0});
        end
    end

    // count one-cycle injection pulses
    always @(posedge clk_sys) begin
        if (rst_n === 1'b1 && inject_start === 1'b1) inj_cnt++;
    end

    // one apb transfer; upper write data is noise the slave must ignore
    // no cycle limit here: only the watchdog may end a wait for pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] wd, input logic er,
                       input logic [7:0] ex);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'($random(seed)), wd};
        // byte strobes stay low on reads
        pstrb <= w ? strb : 4'h0;
        expq.push_back({!w && !er, er, ex});
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // the mirror drops match value writes while matching is on and the trigger self-clears
    task automatic wr(input logic [7:0] i, input logic [7:0] dv);
        apb(1'b1, {2'b00, i, 2'b00}, dv, 1'b0, 8'h00);
        if (!(i == MV && sh[FLT][BIT_TYPE_MATCH_ENABLE])) sh[i] = (i == FE) ? (dv & 8'h7F) : dv;
    endtask

    task automatic rd(input logic [7:0] i);
        apb(1'b0, {2'b00, i, 2'b00}, 8'h00, 1'b0, sh[i]);
    endtask

    // static outputs derived from the mirror, after registered delay has settled
    task automatic check_cfg;
        repeat (3) @(posedge clk_sys);
        cmp_out(self_test_mode, sh[CTL][3]);
        cmp_out(remote_self_test_enable, sh[CTL][0]);
        cmp_out(self_test_clock_select, sh[CTL][2] ? CLK_SRC_25M : (sh[CTL][1] ? CLK_SRC_50M : CLK_SRC_SYSTEM));
        cmp_out(force_errors_enable, |sh[CTL][7:4]);
        cmp_out(forced_error_count, sh[FE][6:0]);
        cmp_out(voltage_gain_code, sh[GN][6:0]);
        cmp_out(sensors_enable, sh[SC0][3:2] == SENSOR_EN_ON);
        cmp_out({sense_gpio1, sense_gpio0}, sh[SC0][1:0]);
        cmp_out(gain_apply, sh[SC1][7]);
    endtask

    function automatic logic exp_fwd(input logic v, input logic [5:0] t, input logic h);
        logic lng;
        lng = t[BIT_LONG_HI] | t[BIT_LONG_LO];
        return v && ((sh[FLT][4] && lng) || (sh[FLT][3] && lng && t == sh[MV][5:0]) ||
            (sh[FLT][2] && h && (t == YUV_TYPE_A || t == YUV_TYPE_B || t == YUV_TYPE_C)));
    endfunction

    // one packet on the filter inputs with random valid levels and 75 mhz mode
    task automatic pkt(input logic v, input logic [5:0] t, input logic h);
        logic f, l;
        f = 1'($random(seed));
        l = 1'($random(seed));
        @(posedge clk_sys);
        pkt_valid <= v;
        packet_type_code <= t;
        hundred_mhz_mode <= h;
        seventy_five_mhz_mode <= 1'($random(seed));
        frame_valid_in <= f;
        line_valid_in <= l;
        repeat (2) @(posedge clk_sys);
        cmp_out(pkt_forward, exp_fwd(v, t, h));
        cmp_out(frame_valid_out, f ^ sh[FLT][1]);
        cmp_out(line_valid_out, l ^ sh[FLT][0]);
    endtask

    task automatic summarize;
        if (expq.size() != 0) errors++;
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // watchdog far beyond the few hundred cycles the tests need
    initial begin
        repeat (50000) @(posedge clk_sys);
        errors++;
        $display("watchdog expired at %0t", $time);
        summarize;
    end

    // main sequence
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {pkt_valid, packet_type_code, hundred_mhz_mode, seventy_five_mhz_mode, frame_valid_in, line_valid_in} = '0;
        pstrb = 4'hF;
        strb = 4'hF;
        sh[FLT] = RST_VIDEO_FILTER_CONFIG;
        sh[MV] = RST_VIDEO_TYPE_MATCH_VALUE;
        sh[FE] = RST_SELF_TEST_FORCE_ERROR;
        sh[CTL] = RST_SELF_TEST_CONTROL;
        sh[GN] = RST_SENSOR_VOLTAGE_GAIN;
        sh[SC0] = RST_SENSOR_CONTROL_FIRST;
        sh[SC1] = RST_SENSOR_CONTROL_SECOND;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        foreach (regs[j]) rd(regs[j]);
        check_cfg;
        $display("test reset_values finished");
        for (int k = 0; k < 4; k++) begin
            foreach (regs[j]) begin
                d = 8'($random(seed));
                if (regs[j] == FLT || regs[j] == FE) d = d & 8'h77;
                wr(regs[j], d);
                rd(regs[j]);
            end
            check_cfg;
        end
        $display("test random_access finished");
        // every clock, sensor enable and sensing code; force field 0 and 4, gain codes 0x40 down to 0x08
        for (int k = 0; k < 4; k++) begin
            wr(CTL, 8'(k << 1) | (k[0] ? 8'h40 : 8'h00));
            wr(SC0, 8'(k * 5));
            wr(GN, 8'h40 >> k);
            wr(SC1, {k[0], 7'h00});
            check_cfg;
        end
        $display("test code_tables finished");
        wr(FLT, 8'h00);
        wr(MV, 8'h2A);
        wr(FLT, 8'h0A);
        wr(MV, 8'h15);
        rd(MV);
        pkt(1'b1, 6'h2A, 1'b0);
        pkt(1'b1, 6'h2A, 1'b1);
        pkt(1'b1, 6'h2B, 1'b1);
        pkt(1'b0, 6'h2A, 1'b1);
        wr(FLT, 8'h00);
        wr(MV, 8'h0A);
        wr(FLT, 8'h09);
        pkt(1'b1, 6'h0A, 1'b1);
        wr(FLT, 8'h06);
        foreach (regs[j]) pkt(1'b1, j[0] ? YUV_TYPE_C : 6'h19 + 6'(j), 1'(j > 2));
        for (int k = 0; k < 48; k++) begin
            if (k % 8 == 0) wr(FLT, 8'($random(seed)) & 8'h1F);
            pkt(1'($random(seed)), 6'($random(seed)), 1'($random(seed)));
        end
        $display("test video_filter finished");
        wr(CTL, 8'h00);
        wr(FLT, 8'h00);
        check_cfg;
        n0 = inj_cnt;
        wr(FE, 8'h85);
        repeat (4) @(posedge clk_sys);
        cmp_out(inj_cnt - n0, 1);
        rd(FE);
        wr(FE, 8'h05);
        wr(CTL, 8'h08);
        wr(FE, 8'h83);
        check_cfg;
        cmp_out(inj_cnt - n0, 2);
        wr(CTL, 8'h00);
        $display("test injection finished");
        apb(1'b1, 12'h048, 8'hFF, 1'b1, 8'h00);
        apb(1'b0, 12'h058, 8'h00, 1'b1, 8'h00);
        apb(1'b1, {2'b00, FLT, 2'b01}, 8'h1F, 1'b1, 8'h00);
        rd(FLT);
        strb = 4'hE;
        apb(1'b1, {2'b00, GN, 2'b00}, 8'h7F, 1'b0, 8'h00);
        strb = 4'hF;
        rd(GN);
        repeat (3) @(posedge clk_sys);
        $display("test bus_errors finished");
        summarize;
    end
endmodule
